/* hdl/level_accumulator.sv */
module level_accumulator #(
  parameter int SAMPLE_W = 16,
  parameter int ACC_W = 24,
  parameter int LEVEL_W = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic add_en,
  input wire logic signed [SAMPLE_W-1:0] sample,
  output logic [LEVEL_W-1:0] level
);

  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] next_sum;
  logic [SAMPLE_W:0] magnitude;
  logic [ACC_W:0] wide_sum;

  // ==========================================================
  // Magnitude sum, saturating so a long loud window cannot wrap
  always_comb begin
    if (sample[SAMPLE_W-1]) begin
      magnitude = (SAMPLE_W+1)'(-$signed({sample[SAMPLE_W-1], sample}));
    end else begin
      magnitude = {1'b0, sample};
    end
    wide_sum = {1'b0, sum} + (ACC_W+1)'(magnitude);
    next_sum = sum;
    if (clear) begin
      next_sum = '0;
    end else if (add_en) begin
      next_sum = wide_sum[ACC_W] ? '1 : wide_sum[ACC_W-1:0];
    end
    if (|sum[ACC_W-1:LEVEL_W]) begin
      level = '1;
    end else begin
      level = sum[LEVEL_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sum <= '0;
    end else begin
      sum <= next_sum;
    end
  end

endmodule // level_accumulator

/* hdl/pcm_level_meter.sv */
// Overview of operation
// - Low result register holds result low byte, read-only, resets zero.
// - Bit 0 of low result register is the active-high result-ready flag.
// - Reading the high result register clears the ready flag, unless a result latches in the same cycle.
// - High result register holds result high byte, read-only, resets zero.
// - Window count zero in meter mode passes linear PCM data straight into result registers.
// - Window count N from 1 to 255 meters N frames of 125 us.
// - Three-bit channel select picks the metered channel; resets to 0.
// - Message mode copies compressed samples into the high result register.
// - Meter mode meters linear samples into both registers, flag set.
// - Meter works only while meter_on is 1; resets to 0.
// - Result registers read with commands 30H and 31H, top bit 0.
// - Window count read with 32H, written with B2H.
// - Control at 33H/B3H: channel bits 2..0, mode 3, meter_on 4.
module pcm_level_meter #(
  parameter int SAMPLE_W = 16,
  parameter int ACC_W = 24
) (
  input wire logic mclk,
  input wire logic resetn,
  input pcm_level_meter_pkg::pcm_sample_type pcm_in,
  input pcm_level_meter_pkg::host_cmd_type host_cmd,
  output logic [7:0] read_data,
  output logic read_valid,
  output logic cmd_reject
);

  import pcm_level_meter_pkg::*;

  // ==========================================================
  // Register state
  logic [15:0] result;
  logic [15:0] next_result;
  logic result_ready_flag;
  logic next_result_ready_flag;
  logic [7:0] sample_window_count;
  logic [7:0] next_sample_window_count;
  logic [7:0] control;
  logic [7:0] next_control;
  logic [7:0] next_read_data;
  logic next_read_valid;
  logic next_cmd_reject;

  // Meter sequencing state
  meter_state_type state;
  meter_state_type next_state;
  logic [7:0] frame_count;
  logic [7:0] next_frame_count;

  // Decoded fields and strobes
  logic [2:0] chan_sel;
  logic meter_mode;
  logic meter_on;
  logic sample_hit;
  logic windowed;
  logic acc_clear;
  logic acc_add;
  logic [15:0] acc_level;
  logic is_write;
  logic [6:0] cmd_reg;
  logic read_high;
  logic window_written;
  logic control_written;

  assign chan_sel = control[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
  assign meter_mode = control[CTRL_MODE_BIT];
  assign meter_on = control[CTRL_ON_BIT];
  assign is_write = host_cmd.command[CMD_WRITE_BIT];
  assign cmd_reg = host_cmd.command[CMD_WRITE_BIT-1:0];

  // Samples are only taken while the meter is on
  assign sample_hit = meter_on && pcm_in.valid &&
                      (pcm_in.channel == chan_sel);
  assign windowed = (sample_window_count != WINDOW_RESET);

  // ==========================================================
  // Host command decode
  always_comb begin
    next_read_data = READ_IDLE;
    next_read_valid = 1'b0;
    next_cmd_reject = 1'b0;
    next_sample_window_count = sample_window_count;
    next_control = control;
    read_high = 1'b0;
    window_written = 1'b0;
    control_written = 1'b0;
    if (host_cmd.valid && !is_write) begin
      next_read_valid = 1'b1;
      if (cmd_reg == CMD_RESULT_LOW) begin
        // Low byte with flag in bit 0
        next_read_data = {result[7:1], result_ready_flag};
      end else if (cmd_reg == CMD_RESULT_HIGH) begin
        next_read_data = result[15:8];
        read_high = 1'b1;
      end else if (cmd_reg == CMD_WINDOW_COUNT) begin
        next_read_data = sample_window_count;
      end else if (cmd_reg == CMD_CONTROL) begin
        next_read_data = control & CTRL_WRITE_MASK;
      end else begin
        next_read_valid = 1'b0;
        next_cmd_reject = 1'b1;
      end
    end else if (host_cmd.valid) begin
      if (cmd_reg == CMD_WINDOW_COUNT) begin
        next_sample_window_count = host_cmd.data;
        window_written = 1'b1;
      end else if (cmd_reg == CMD_CONTROL) begin
        next_control = host_cmd.data & CTRL_WRITE_MASK;
        control_written = 1'b1;
      end else begin
        // Writes to the result registers are refused
        next_cmd_reject = 1'b1;
      end
    end
  end

  // ==========================================================
  // Window sequencing
  always_comb begin
    next_state = state;
    next_frame_count = frame_count;
    acc_clear = 1'b0;
    acc_add = 1'b0;
    case (state)
      ST_IDLE: begin
        acc_clear = 1'b1;
        next_frame_count = '0;
        // Windowed metering only in meter mode
        if (meter_on && meter_mode == MODE_METER && windowed) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        // A register write restarts the window cleanly
        if (!meter_on || meter_mode != MODE_METER || !windowed ||
            window_written || control_written) begin
          next_state = ST_IDLE;
        end else if (sample_hit) begin
          acc_add = 1'b1;
          next_frame_count = frame_count + 8'h01;
          if (frame_count + 8'h01 == sample_window_count) begin
            next_state = ST_LATCH;
          end
        end
      end
      ST_LATCH: begin
        acc_clear = 1'b1;
        next_frame_count = '0;
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  level_accumulator #(
    .SAMPLE_W(SAMPLE_W),
    .ACC_W(ACC_W),
    .LEVEL_W(16)
  ) u_acc (
    .mclk(mclk),
    .resetn(resetn),
    .clear(acc_clear),
    .add_en(acc_add),
    .sample(pcm_in.linear),
    .level(acc_level)
  );

  // ==========================================================
  // Result and ready flag
  always_comb begin
    next_result = result;
    next_result_ready_flag = result_ready_flag;
    // High byte read clears the flag
    if (read_high) begin
      next_result_ready_flag = 1'b0;
    end
    if (sample_hit && meter_mode == MODE_MESSAGE) begin
      // Compressed data passes into the high byte
      next_result = {pcm_in.compressed, result[7:0]};
    end else if (sample_hit && !windowed) begin
      next_result = pcm_in.linear;
      next_result_ready_flag = 1'b1;
    end else if (state == ST_LATCH) begin
      // Latch level, set wins over clear
      next_result = acc_level;
      next_result_ready_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      result <= RESULT_RESET;
      result_ready_flag <= 1'b0;
      sample_window_count <= WINDOW_RESET;
      control <= CONTROL_RESET;
      read_data <= READ_IDLE;
      read_valid <= 1'b0;
      cmd_reject <= 1'b0;
      state <= ST_IDLE;
      frame_count <= '0;
    end else begin
      result <= next_result;
      result_ready_flag <= next_result_ready_flag;
      sample_window_count <= next_sample_window_count;
      control <= next_control;
      read_data <= next_read_data;
      read_valid <= next_read_valid;
      cmd_reject <= next_cmd_reject;
      state <= next_state;
      frame_count <= next_frame_count;
    end
  end

endmodule // pcm_level_meter

/* hdl/pcm_level_meter_pkg.sv */
package pcm_level_meter_pkg;

  // ==========================================================
  // Command bytes: bit 7 selects write, bits 6..0 the register
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [6:0] CMD_RESULT_LOW = 7'h30;
  localparam logic [6:0] CMD_RESULT_HIGH = 7'h31;
  localparam logic [6:0] CMD_WINDOW_COUNT = 7'h32;
  localparam logic [6:0] CMD_CONTROL = 7'h33;

  // ==========================================================
  // Control register layout
  localparam int CTRL_CHAN_LSB = 0;
  localparam int CTRL_CHAN_MSB = 2;
  localparam int CTRL_MODE_BIT = 3;
  localparam int CTRL_ON_BIT = 4;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h1F;

  // Low result register: ready flag sits in bit 0
  localparam int READY_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] WINDOW_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Mode encodings of the control mode bit
  localparam logic MODE_MESSAGE = 1'b0;
  localparam logic MODE_METER = 1'b1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [2:0] channel;
    logic [15:0] linear;
    logic [7:0] compressed;
  } pcm_sample_type;

  typedef struct packed {
    logic valid;
    logic [7:0] command;
    logic [7:0] data;
  } host_cmd_type;

  // Gray coded along idle -> run -> latch
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_LATCH = 2'b11
  } meter_state_type;

endpackage

/* sim/host_model.sv */
module host_model (
  input wire logic mclk,
  output pcm_level_meter_pkg::host_cmd_type host_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcm_level_meter_pkg::*;
  initial host_cmd = '{1'b0, 8'hFF, 8'hFF};
  task automatic req(input logic [7:0] c, input logic [7:0] d);
    host_cmd = '{1'b1, c, d};
    @(negedge mclk);
  endtask
  // Released lines flip so a stale byte never looks held
  task automatic rel();
    host_cmd = '{1'b0, ~host_cmd.command, ~host_cmd.data};
  endtask
endmodule // host_model

/* sim/pcm_level_meter_properties.sv */
module pcm_level_meter_properties (
  input wire logic mclk,
  input wire logic resetn,
  input wire pcm_level_meter_pkg::pcm_sample_type pcm_in,
  input wire pcm_level_meter_pkg::host_cmd_type host_cmd,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic cmd_reject
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcm_level_meter_pkg::*;
  // ====================================
  // Command decode
  logic rd, wr, ro;
  assign rd = host_cmd.valid && host_cmd.command inside {[8'h30:8'h33]};
  assign wr = host_cmd.valid && host_cmd.command inside {8'hB2, 8'hB3};
  assign ro = host_cmd.valid && host_cmd.command inside {8'hB0, 8'hB1};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_pair(logic [7:0] a, logic [7:0] b);
    host_cmd.valid && host_cmd.command == a ##1
    host_cmd.valid && host_cmd.command == b;
  endsequence
  // Quiet PCM keeps a late latch from setting the flag again
  sequence s_clear;
    (!pcm_in.valid [*3] ##1 s_pair(8'h31, 8'h30)) and !pcm_in.valid [*5];
  endsequence
  a_read_answer: assert property (rd |=> read_valid && !cmd_reject)
    else $error("read not answered");
  a_write_silent: assert property (wr |=> !read_valid && !cmd_reject)
    else $error("write answered");
  a_ro_refused: assert property (ro |=> cmd_reject && !read_valid)
    else $error("result write taken");
  a_unmapped_refused: assert property (host_cmd.valid &&
    !(host_cmd.command[6:0] inside {[7'h30:7'h33]}) |=> cmd_reject)
    else $error("unmapped not refused");
  a_idle_zero: assert property (!read_valid |-> read_data == READ_IDLE)
    else $error("read data not idle");
  a_no_spurious: assert property ((read_valid || cmd_reject)
    |-> $past(host_cmd.valid))
    else $error("answer without command");
  a_window_back: assert property (s_pair(8'hB2, 8'h32)
    |=> read_data == $past(host_cmd.data, 2))
    else $error("window readback wrong");
  a_ctrl_back: assert property (s_pair(8'hB3, 8'h33)
    |=> read_data == ($past(host_cmd.data, 2) & CTRL_WRITE_MASK))
    else $error("control readback wrong");
  a_flag_clear: assert property (s_clear |=> !read_data[READY_BIT])
    else $error("flag not cleared");
endmodule // pcm_level_meter_properties

bind pcm_level_meter pcm_level_meter_properties u_props (.mclk(mclk),
  .resetn(resetn), .pcm_in(pcm_in), .host_cmd(host_cmd),
  .read_data(read_data), .read_valid(read_valid), .cmd_reject(cmd_reject));

/* sim/tb.sv */
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("unexpected %s exp %h got %h", n, e, g); error_cnt++; end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcm_level_meter_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  pcm_sample_type pcm_in = '0;
  host_cmd_type host_cmd;
  logic [7:0] read_data;
  logic read_valid, cmd_reject;
  logic [9:0] ans, got;
  logic [9:0] exp_q[$];
  logic [15:0] rnd = 16'hFF9A;
  logic [7:0] rej[4] = '{8'hB0, 8'hB1, 8'h34, 8'hB4};
  logic [7:0] wins[3] = '{8'h01, 8'h03, 8'hFF};
  int error_cnt = 0, n_compared = 0;
  int res = 0, acc = 0, cnt = 0, win = 0, ctl = 0, flag = 0;
  always #50 mclk = ~mclk;
  pcm_level_meter u_dut (.mclk(mclk), .resetn(resetn), .pcm_in(pcm_in),
    .host_cmd(host_cmd), .read_data(read_data), .read_valid(read_valid),
    .cmd_reject(cmd_reject));
  host_model u_host (.mclk(mclk), .host_cmd(host_cmd));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmd(input logic [7:0] c, input logic [7:0] d);
    case (c)
      8'h30: exp_q.push_back({2'b10, res[7:1], flag[0]});
      8'h31: begin
        exp_q.push_back({2'b10, res[15:8]});
        flag = 0;
      end
      8'h32: exp_q.push_back({2'b10, 8'(win)});
      8'h33: exp_q.push_back({2'b10, 8'(ctl)});
      8'hB2, 8'hB3: begin
        if (c[0]) ctl = d & 8'h1F;
        else win = d;
        acc = 0;
        cnt = 0;
      end
      default: exp_q.push_back(10'h100);
    endcase
    u_host.req(c, d);
  endtask
  task automatic sample(input int ch, input logic [15:0] lin);
    int v;
    v = $signed(lin);
    pcm_in = '{1'b1, 3'(ch), lin, ~lin[15:8]};
    if (ch == ctl % 8 && ctl[4]) begin
      if (!ctl[3]) res[15:8] = ~lin[15:8];
      else if (win == 0) begin
        res = lin;
        flag = 1;
      end else begin
        acc += (v < 0) ? -v : v;
        cnt++;
        if (cnt == win) begin
          res = (acc > 65535) ? 65535 : acc;
          flag = 1;
          acc = 0;
          cnt = 0;
        end
      end
    end
    @(negedge mclk);
    pcm_in.valid = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic read_result();
    cmd(8'h30, 8'h00);
    cmd(8'h31, 8'h00);
  endtask
  always @(negedge mclk) begin
    if (resetn && (read_valid !== 1'b0 || cmd_reject !== 1'b0)) begin
      ans = exp_q.size() > 0 ? exp_q.pop_front() : 10'h000;
      got = {read_valid, cmd_reject, read_data};
      `CHK("flag", ans[0], got[0])
      `CHK("ans", ans, got)
    end
  end
  initial begin
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    for (int i = 0; i < 4; i++) cmd(8'h30 + 8'(i), 8'h00);
    foreach (rej[i]) cmd(rej[i], 8'h55);
    cmd(8'hB2, rnd[7:0]);
    cmd(8'h32, 8'h00);
    cmd(8'hB3, 8'hFF);
    cmd(8'h33, 8'h00);
    for (int ch = 0; ch < 8; ch++) begin
      cmd(8'hB3, 8'h10 | 8'(ch));
      u_host.rel();
      for (int k = 0; k < 8; k++) begin
        rnd = lfsr(rnd);
        sample(k, rnd);
      end
      cmd(8'h31, 8'h00);
    end
    cmd(8'hB2, 8'h00);
    cmd(8'hB3, 8'h08);
    u_host.rel();
    sample(0, rnd);
    for (int k = 0; k < 4; k++) begin
      if (k == 1) cmd(8'hB3, 8'h1A);
      u_host.rel();
      rnd = lfsr(rnd);
      sample(2, rnd);
      read_result();
      // Next pass releases or commands on this edge, never both
      cmd(8'h30, 8'h00);
    end
    foreach (wins[i]) begin
      cmd(8'hB2, wins[i]);
      cmd(8'hB3, 8'h1D);
      u_host.rel();
      repeat (3 * wins[i]) begin
        rnd = lfsr(rnd);
        sample(rnd[0] ? 6 : 5, rnd);
      end
      read_result();
      cmd(8'h30, 8'h00);
    end
    u_host.rel();
    repeat (3) @(negedge mclk);
    `CHK("left", 0, exp_q.size())
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end
  task automatic report_and_stop();
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
endmodule // tb
